// ==== core/buf_cfg_pkg.sv ====
package buf_cfg_pkg;
  // Register map
  localparam logic [7:0] REG_BUF_CFG2 = 8'h27;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam int FLUSH_BIT = 7;
  localparam int WAKE_SRC_BIT = 6;
  localparam int THR_MSB = 5;
  // Buffer modes from the first configuration register
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_STREAM = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_TRIG = 2'h3;
  // Sizes
  localparam logic [6:0] TRIG_SPAN = 7'h20;
  localparam int FIFO_DEPTH = 16;
  localparam int SAMPLE_W = 36;
  localparam int PERIOD_W = 8;
  // Power states
  typedef enum logic [1:0] {
    ST_WAKE = 2'b01,
    ST_SLEEP = 2'b10
  } power_state_type;
endpackage

// ==== core/sample_fifo.sv ====
// Sample storage; clear has priority over push and pop
module sample_fifo #(
  parameter int WIDTH = buf_cfg_pkg::SAMPLE_W,
  parameter int DEPTH = buf_cfg_pkg::FIFO_DEPTH,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // A pop in the same cycle frees a slot, so a full FIFO can still accept
  assign out_valid = (cnt_r != '0);
  assign in_ready = (cnt_r != CW'(DEPTH)) | out_ready;
  assign out_data = mem[rd_r];
  assign count = cnt_r;
  assign push = in_valid & in_ready & ~clear;
  assign pop = out_valid & out_ready & ~clear;

  always_comb
  begin
    wr_nxt = push ? step(wr_r) : wr_r;
    rd_nxt = pop ? step(rd_r) : rd_r;
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    if (clear)
    begin
      wr_nxt = '0;
      rd_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; the pointers say what is valid
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_r] <= in_data;
  end
endmodule // sample_fifo

// ==== core/sleep_countdown.sv ====
// Auto-sleep countdown in output-data-rate periods; period 0 never expires
module sleep_countdown #(
  parameter int W = buf_cfg_pkg::PERIOD_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control
  input wire logic [W-1:0] period,
  input wire logic tick,
  input wire logic restart,
  // Status
  output logic expire
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic exp_r, exp_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Restart wins over a tick so a fresh activity always gets full time
  always_comb
  begin
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (restart)
      cnt_nxt = period;
    else if (tick && cnt_r != '0)
    begin
      cnt_nxt = cnt_r - W'(1);
      exp_nxt = (cnt_r == W'(1));
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expire = exp_r;
endmodule // sleep_countdown

// ==== core/sample_buffer_flush_watermark_ctrl.sv ====
// Second buffer configuration register with flush, wake source and threshold
module sample_buffer_flush_watermark_ctrl #(
  parameter int SW = buf_cfg_pkg::SAMPLE_W,
  parameter int DEPTH = buf_cfg_pkg::FIFO_DEPTH,
  localparam int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port from the serial interface logic
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Context from other blocks
  input wire logic [1:0] buf_mode,
  input wire logic [7:0] auto_sleep_period,
  input wire logic odr_tick,
  input wire logic other_wake_event,
  input wire logic trig_event,
  // Incoming samples
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [SW-1:0] smp_data,
  // Host sample readout
  input wire logic rd_req,
  output logic rd_ack,
  output logic [SW-1:0] rd_data,
  // Status
  output logic [5:0] sample_count,
  output logic fill_flag,
  output logic overflow_flag,
  output logic sleep_mode,
  output logic gate_clear
);
  // Configuration and status state
  logic [6:0] cfg_r, cfg_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  buf_cfg_pkg::power_state_type state_r, state_nxt;
  logic hit_r, hit_nxt, done_r, done_nxt, wait_r, wait_nxt;
  logic ovf_r, ovf_nxt, fill_r, fill_nxt, prev_r, prev_nxt;
  logic [5:0] post_r, post_nxt;
  logic ack_r;
  logic [SW-1:0] rdd_r;
  logic gclr_r, gclr_nxt;
  // Decodes and events
  logic cfg_sel, flush_cmd, wake_en;
  logic [5:0] thr, lim, cnt6;
  logic m_off, m_stream, m_stop, m_trig, pre, full;
  logic clr, discard, drop, push, host_pop;
  logic buf_src, flags, buf_wake_ev, host_clear_ev;
  logic trig_take, go_sleep, go_wake, expire, restart;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [SW-1:0] f_out_data;
  logic [CW-1:0] f_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Decodes
  assign cfg_sel = (reg_addr == buf_cfg_pkg::REG_BUF_CFG2);
  assign flush_cmd = reg_wr & cfg_sel
                   & reg_wdata[buf_cfg_pkg::FLUSH_BIT];
  assign wake_en = cfg_r[buf_cfg_pkg::WAKE_SRC_BIT];
  assign thr = cfg_r[buf_cfg_pkg::THR_MSB:0];
  assign m_off = (buf_mode == buf_cfg_pkg::MODE_OFF);
  assign m_stream = (buf_mode == buf_cfg_pkg::MODE_STREAM);
  assign m_stop = (buf_mode == buf_cfg_pkg::MODE_STOP);
  assign m_trig = (buf_mode == buf_cfg_pkg::MODE_TRIG);
  assign cnt6 = 6'(f_cnt);
  assign full = (f_cnt == CW'(DEPTH));
  assign pre = m_trig & ~hit_r;

  // Post-trigger span; a threshold at or past the span leaves nothing
  assign lim = ({1'b0, thr} >= buf_cfg_pkg::TRIG_SPAN) ? 6'h00
             : 6'(buf_cfg_pkg::TRIG_SPAN - {1'b0, thr});

  ////////////////////////////////////////////////////////////////////////
  // Buffer path; mode off and flush beat any sample in flight
  assign clr = flush_cmd | m_off | (go_sleep & m_trig);
  assign discard = m_off | (pre & thr == 6'h00) | clr;
  assign f_in_valid = smp_valid & ~discard & ~done_r;
  assign smp_ready = discard | (~done_r & f_in_ready);
  assign host_pop = rd_req & f_out_valid & ~clr;
  // Stream drops the oldest when full; pre-trigger keeps only thr samples
  assign drop = f_in_valid & f_out_valid & ~host_pop
              & ((m_stream & full) | (pre & (full | cnt6 >= thr)));
  assign f_out_ready = host_pop | drop;
  assign push = f_in_valid & f_in_ready;

  sample_fifo #(
    .WIDTH(SW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clear(clr),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(smp_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data),
    .count(f_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Wake/sleep sources
  assign buf_src = wake_en & (m_stream | m_stop);
  assign flags = fill_r | ovf_r;
  assign buf_wake_ev = buf_src & flags & ~prev_r;
  assign host_clear_ev = buf_src & flags & (flush_cmd | host_pop);
  assign trig_take = pre & trig_event & ~wait_r;
  // A captured trigger holds WAKE until the buffer is emptied
  assign go_sleep = (state_r == buf_cfg_pkg::ST_WAKE)
                  & expire & ~hit_r;
  assign go_wake = (state_r == buf_cfg_pkg::ST_SLEEP)
                 & (other_wake_event | buf_wake_ev | trig_take);
  assign restart = other_wake_event | buf_wake_ev | host_clear_ev
                 | trig_take | go_sleep | go_wake;

  sleep_countdown #(
    .W(buf_cfg_pkg::PERIOD_W)
  ) u_aslp (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .period(auto_sleep_period),
    .tick(odr_tick),
    .restart(restart),
    .expire(expire)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file; flush is a pulse and never stored
  always_comb
  begin
    cfg_nxt = cfg_r;
    rdata_nxt = rdata_r;
    if (reg_wr && cfg_sel)
      cfg_nxt = reg_wdata[6:0];
    if (reg_rd)
      rdata_nxt = cfg_sel ? {1'b0, cfg_r} : 8'h00;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_r <= buf_cfg_pkg::CFG2_RESET[6:0];
      rdata_r <= 8'h00;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags, trigger capture and power state
  always_comb
  begin
    state_nxt = state_r;
    if (go_sleep)
      state_nxt = buf_cfg_pkg::ST_SLEEP;
    else if (go_wake)
      state_nxt = buf_cfg_pkg::ST_WAKE;
    // Fill flag follows the count every cycle
    fill_nxt = ~m_off & ~clr & (thr != 6'h00) & (cnt6 >= thr);
    prev_nxt = flags;
    post_nxt = post_r;
    hit_nxt = hit_r;
    done_nxt = done_r;
    wait_nxt = wait_r & (state_r != buf_cfg_pkg::ST_SLEEP);
    if (trig_take)
    begin
      hit_nxt = 1'b1;
      post_nxt = 6'h00;
      done_nxt = (lim == 6'h00);
    end
    else if (hit_r && push)
    begin
      post_nxt = post_r + 6'h01;
      done_nxt = (post_r + 6'h01 == lim);
    end
    // Overflow: reads clear it, but a new overflow in that cycle wins
    ovf_nxt = ovf_r & ~host_pop;
    if ((smp_valid & m_stop & full & ~discard) | (m_stream & drop)
        | (~done_r & done_nxt & (trig_take | hit_r)))
      ovf_nxt = 1'b1;
    // Emptying after capture re-arms, but only after a sleep
    if (hit_r && done_r && host_pop && f_cnt == CW'(1))
    begin
      hit_nxt = 1'b0;
      done_nxt = 1'b0;
      wait_nxt = 1'b1;
    end
    gclr_nxt = clr | (host_pop & f_cnt == CW'(1));
    if (clr)
    begin
      ovf_nxt = 1'b0;
      hit_nxt = 1'b0;
      done_nxt = 1'b0;
      post_nxt = 6'h00;
      wait_nxt = wait_r | (hit_r & ~m_off);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= buf_cfg_pkg::ST_WAKE;
      fill_r <= 1'b0;
      ovf_r <= 1'b0;
      prev_r <= 1'b0;
      post_r <= 6'h00;
      hit_r <= 1'b0;
      done_r <= 1'b0;
      wait_r <= 1'b0;
      gclr_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      fill_r <= fill_nxt;
      ovf_r <= ovf_nxt;
      prev_r <= prev_nxt;
      post_r <= post_nxt;
      hit_r <= hit_nxt;
      done_r <= done_nxt;
      wait_r <= wait_nxt;
      gclr_r <= gclr_nxt;
    end
  end

  // Readout holds the last sample; data path needs no reset value
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_r <= 1'b0;
    else
      ack_r <= host_pop;
  end

  always_ff @(posedge ref_clk)
  begin
    if (host_pop)
      rdd_r <= f_out_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata_r;
  assign rd_ack = ack_r;
  assign rd_data = rdd_r;
  assign sample_count = cnt6;
  assign fill_flag = fill_r;
  assign overflow_flag = ovf_r;
  assign sleep_mode = (state_r == buf_cfg_pkg::ST_SLEEP);
  assign gate_clear = gclr_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  property p_flush_empties;
    flush_cmd |=> (sample_count == 6'h00) && !overflow_flag && gate_clear;
  endproperty
  a_flush_empties: assert property (p_flush_empties)
    else $error("flush left samples or flags");

  property p_flush_reads_zero;
    reg_rd && cfg_sel |=> !reg_rdata[buf_cfg_pkg::FLUSH_BIT];
  endproperty
  a_flush_reads_zero: assert property (p_flush_reads_zero)
    else $error("flush bit read back as one");

  property p_src_gated;
    !wake_en || !(m_stream || m_stop) |-> !buf_wake_ev && !host_clear_ev;
  endproperty
  a_src_gated: assert property (p_src_gated)
    else $error("buffer flags steered wake logic while gated");

  property p_expire_sleeps;
    !sleep_mode && expire && !hit_r |=> sleep_mode;
  endproperty
  a_expire_sleeps: assert property (p_expire_sleeps)
    else $error("countdown expired but device stayed awake");

  property p_clear_stays_awake;
    host_clear_ev && !sleep_mode && !expire |=> !sleep_mode ##1 !expire;
  endproperty
  a_clear_stays_awake: assert property (p_clear_stays_awake)
    else $error("host flag clear did not hold WAKE");

  property p_fill_rises;
    !m_off && !clr && thr != 6'h00 && cnt6 >= thr
      && $stable(cnt6) && $stable(thr) |=> fill_flag;
  endproperty
  a_fill_rises: assert property (p_fill_rises)
    else $error("count at threshold but fill flag low");

  property p_zero_thr;
    (thr == 6'h00) [*2] |-> !fill_flag;
  endproperty
  a_zero_thr: assert property (p_zero_thr)
    else $error("fill flag with zero threshold");

  property p_fill_follows;
    $fell(cnt6 >= thr) && $stable(thr) |=> !fill_flag;
  endproperty
  a_fill_follows: assert property (p_fill_follows)
    else $error("fill flag stayed after count dropped");

  property p_pre_cap;
    pre && thr != 6'h00 && cnt6 <= thr && $stable(thr) |=> cnt6 <= thr;
  endproperty
  a_pre_cap: assert property (p_pre_cap)
    else $error("pre-trigger samples exceeded threshold");

  property p_done_stops;
    done_r |-> !f_in_valid && ($past(done_r) || overflow_flag);
  endproperty
  a_done_stops: assert property (p_done_stops)
    else $error("collection continued after trigger span");

  property p_off_clears;
    m_off ##1 m_off |-> sample_count == 6'h00 && !overflow_flag && !fill_flag;
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("mode off left count or flags");

  c_flush: cover property (flush_cmd && sample_count != 6'h00);
  c_trigger: cover property (trig_take ##[1:100] done_r);
  c_sleep: cover property (go_sleep && m_stream && wake_en);
  c_stream_drop: cover property (drop && m_stream);
endmodule // sample_buffer_flush_watermark_ctrl

// ==== bench/host_model.sv ====
// Host side of the register port and sample readout
module host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Sample readout
  output logic rd_req,
  input wire logic rd_ack,
  input wire logic [buf_cfg_pkg::SAMPLE_W-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rd_req = 1'b0;
  end

  // One strobe cycle; released lines show the inverse of the last value
  // so a design that keeps sampling them after the strobe gets garbage
  task automatic bus_op(input logic wr, input logic [7:0] addr,
                        input logic [7:0] data);
    @(posedge ref_clk);
    #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = addr;
    reg_wdata = data;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~addr;
    reg_wdata = ~data;
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    bus_op(1'b1, addr, data);
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    bus_op(1'b0, addr, 8'h00);
    data = reg_rdata;
  endtask

  // Reading a sample is how the host clears the buffer flags
  task automatic pop(output logic ok,
                     output logic [buf_cfg_pkg::SAMPLE_W-1:0] data);
    @(posedge ref_clk);
    #1;
    rd_req = 1'b1;
    @(posedge ref_clk);
    #1;
    rd_req = 1'b0;
    ok = rd_ack;
    data = rd_data;
  endtask
endmodule // host_model

// ==== bench/sample_buffer_flush_watermark_ctrl_tb_top.sv ====
// Sequence of host accesses with expected results
module sample_buffer_flush_watermark_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr, reg_rd, rd_req, rd_ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd8;
  logic [1:0] buf_mode = 2'h0;
  logic [7:0] auto_sleep_period = 8'h00;
  logic odr_tick = 1'b0;
  logic other_wake_event = 1'b0;
  logic trig_event = 1'b0;
  logic smp_valid = 1'b0;
  logic smp_ready, fill_flag, overflow_flag, sleep_mode, gate_clear, ok;
  logic [35:0] smp_data = 36'h0;
  logic [35:0] rd_data, got;
  logic [5:0] sample_count;
  int errors = 0;
  int checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  sample_buffer_flush_watermark_ctrl u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .buf_mode(buf_mode), .auto_sleep_period(auto_sleep_period),
    .odr_tick(odr_tick), .other_wake_event(other_wake_event),
    .trig_event(trig_event),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
    .rd_req(rd_req), .rd_ack(rd_ack), .rd_data(rd_data),
    .sample_count(sample_count), .fill_flag(fill_flag),
    .overflow_flag(overflow_flag), .sleep_mode(sleep_mode),
    .gate_clear(gate_clear)
  );

  host_model u_host (
    .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rd_req(rd_req), .rd_ack(rd_ack), .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparisons, one per kind of result
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [35:0] e,
                          input logic [35:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic summarize;
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus helpers, all changes 1 ns after the rising edge
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Stream mode never stalls, so one sample goes in per cycle
  task automatic push_n(input int n, input logic [35:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      #1;
      smp_valid = 1'b1;
      smp_data = base + 36'(i);
    end
    idle(1);
    smp_valid = 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      idle(1);
      odr_tick = 1'b1;
      idle(1);
      odr_tick = 1'b0;
      idle(2);
    end
  endtask

  // Bounded wait: a countdown that never expires ends the run
  task automatic tick_until_sleep;
    for (int i = 0; i < 8 && sleep_mode !== 1'b1; i++)
      tick(1);
    chk_bit("sleep_mode", 1'b1, sleep_mode);
    if (sleep_mode !== 1'b1)
      summarize();
  endtask

  task automatic wake;
    idle(1);
    other_wake_event = 1'b1;
    idle(1);
    other_wake_event = 1'b0;
    idle(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    idle(20);
    arst_n = 1'b1;
    u_host.read_reg(8'h27, rd8);
    chk_byte("cfg reset", 8'h00, rd8);
    u_host.write_reg(8'h26, 8'h3f);
    u_host.read_reg(8'h28, rd8);
    chk_byte("unmapped", 8'h00, rd8);
    u_host.read_reg(8'h27, rd8);
    chk_byte("cfg kept", 8'h00, rd8);
    // Threshold of 6 in stream mode
    buf_mode = buf_cfg_pkg::MODE_STREAM;
    u_host.write_reg(8'h27, 8'h06);
    push_n(5, 36'h0);
    idle(2);
    chk_bit("fill below", 1'b0, fill_flag);
    push_n(1, 36'h5);
    idle(2);
    chk_bit("fill at", 1'b1, fill_flag);
    u_host.pop(ok, got);
    chk_word("pop data", 36'h0, got);
    chk_byte("count", 8'h05, {2'h0, sample_count});
    idle(2);
    chk_bit("fill after pop", 1'b0, fill_flag);
    // Flush clears contents and gate status, bit never reads back
    u_host.write_reg(8'h27, 8'h86);
    chk_bit("gate_clear", 1'b1, gate_clear);
    chk_byte("count flushed", 8'h00, {2'h0, sample_count});
    u_host.read_reg(8'h27, rd8);
    chk_byte("flush readback", 8'h06, rd8);
    // Zero threshold never flags; overrun drops the oldest
    u_host.write_reg(8'h27, 8'h00);
    push_n(4, 36'h100);
    idle(2);
    chk_bit("fill thr0", 1'b0, fill_flag);
    push_n(13, 36'h104);
    idle(2);
    chk_bit("overflow", 1'b1, overflow_flag);
    chk_byte("count full", 8'h10, {2'h0, sample_count});
    u_host.pop(ok, got);
    chk_bit("rd_ack", 1'b1, ok);
    chk_word("pop after drop", 36'h101, got);
    idle(1);
    chk_bit("overflow cleared", 1'b0, overflow_flag);
    // Disabling the buffer clears the samples and the flags, not the register
    u_host.write_reg(8'h27, 8'h01);
    idle(2);
    chk_bit("fill thr1", 1'b1, fill_flag);
    buf_mode = buf_cfg_pkg::MODE_OFF;
    idle(2);
    chk_byte("count off", 8'h00, {2'h0, sample_count});
    chk_bit("fill off", 1'b0, fill_flag);
    // Flag-driven countdown with wake source enabled
    buf_mode = buf_cfg_pkg::MODE_STREAM;
    auto_sleep_period = 8'h03;
    u_host.write_reg(8'h27, 8'h41);
    wake();
    push_n(1, 36'h200);
    idle(2);
    tick(2);
    u_host.pop(ok, got);
    tick(2);
    chk_bit("wake held", 1'b0, sleep_mode);
    push_n(1, 36'h201);
    tick_until_sleep();
    // With the source disabled flags are ignored and sleep still comes
    wake();
    chk_bit("woken", 1'b0, sleep_mode);
    u_host.write_reg(8'h27, 8'h01);
    tick_until_sleep();
    // Triggered mode: the threshold caps pre-trigger samples, newest kept
    buf_mode = buf_cfg_pkg::MODE_TRIG;
    u_host.write_reg(8'h27, 8'h83);
    push_n(5, 36'h300);
    idle(2);
    chk_byte("pre count", 8'h03, {2'h0, sample_count});
    u_host.pop(ok, got);
    chk_word("pre oldest", 36'h302, got);
    // Threshold 20 leaves 12 post-trigger slots, so 14 fit the store
    u_host.write_reg(8'h27, 8'h94);
    push_n(2, 36'h400);
    idle(1);
    trig_event = 1'b1;
    idle(1);
    trig_event = 1'b0;
    push_n(14, 36'h500);
    idle(2);
    chk_byte("post count", 8'h0e, {2'h0, sample_count});
    chk_bit("post overflow", 1'b1, overflow_flag);
    chk_bit("post stall", 1'b0, smp_ready);
    chk_bit("trigger wake", 1'b0, sleep_mode);
    // Stop mode refuses samples once full; flush then clears the flag
    buf_mode = buf_cfg_pkg::MODE_STOP;
    u_host.write_reg(8'h27, 8'h80);
    push_n(17, 36'h600);
    idle(2);
    chk_byte("stop count", 8'h10, {2'h0, sample_count});
    chk_bit("stop overflow", 1'b1, overflow_flag);
    u_host.write_reg(8'h27, 8'h80);
    chk_byte("stop flushed", 8'h00, {2'h0, sample_count});
    chk_bit("overflow flushed", 1'b0, overflow_flag);
    summarize();
  end
endmodule // sample_buffer_flush_watermark_ctrl_tb_top
